// ==== inc/self_program_cfg.svh ====
`ifndef SELF_PROGRAM_CFG_SVH
`define SELF_PROGRAM_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define CTRL_INDEX        8'h37
`define CTRL_RESET        5'h00
`define BIT_CLEAR_BUF     4
`define BIT_READ_FUSE     3
`define BIT_PAGE_WRITE    2
`define BIT_PAGE_ERASE    1
`define BIT_STORE_EN      0

// ****************************************
// Command patterns in the low five bits
// ****************************************
`define CMD_CLEAR_BUF     5'h11
`define CMD_READ_FUSE     5'h09
`define CMD_PAGE_WRITE    5'h05
`define CMD_PAGE_ERASE    5'h03
`define CMD_FILL_BUF      5'h01

// ****************************************
// Windows, timing and fuse layout
// ****************************************
`define STORE_WINDOW      3'h4
`define LOAD_WINDOW_MIN   3'h2
`define OP_MIN_TIME_NS    3700000
`define OP_MAX_TIME_NS    4500000
`define CLK_PERIOD_NS     50
`define OP_MIN_CYCLES     ((`OP_MIN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OP_MAX_CYCLES     (`OP_MAX_TIME_NS / `CLK_PERIOD_NS)
`define PTR_LOCK          16'h0001
`define PTR_FUSE_LOW      16'h0000
`define PTR_FUSE_HIGH     16'h0003
`define LOCK_ERASED       2'h3
`define DEBUG_LINK_ENABLE_FUSE_BIT          6
`define BUF_ERASED        16'hffff

`endif

// ==== inc/self_program_pkg.sv ====
package self_program_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_BUSY  = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_ERASE = 2'b00,
		OP_WRITE = 2'b01,
		OP_LOCK  = 2'b10
	} op_kind_t;
endpackage

// ==== rtl/self_program_flash_control.sv ====
// Notes on behaviour
// - Erase, write and lock write each last 3.7 to 4.5 ms, timed here.
// - Control bits 7 to 5 always read as zero.
// - Writing the clear-buffer command empties the whole page buffer.
// - Read-fuse plus store-enable lets a load within three cycles return fuse/lock.
// - Page-write command plus store within four cycles writes buffer to page.
// - Page-write bit clears when write ends or window lapses.
// - CPU is halted for the whole page write or page erase.
// - Page-erase command plus store within four cycles erases the page.
// - Page-erase bit clears when erase ends or window lapses.
// - Store-enable opens a four-cycle store window for the combined command.
// - Store-enable alone puts the data pair into the buffer word, pointer LSB ignored.
// - Store-enable clears after store or lapse, held through erase and write.
// - Only five command patterns act; any other write is ignored.
// - Two lock bits, 1 unprogrammed, 0 programmed; only chip erase restores ones (here hresetn also reloads ones).
// - Programmed debug enable fuse still allows debug reads of program memory.
// - Both lock bits one: no restrictions.
// - Mode 2 blocks external programming, locks fuses, disables debug link.
// - Mode 3 also blocks external verification.
// - Page buffer empties after page write and after reset.
// - Pointer 1 selects lock, 0 fuse low, 3 fuse high.
// - Fuse and lock read back zero programmed, one unprogrammed.
// - EEPROM write in progress blocks programming and fuse reads.
//
// The implementer's own choice: the AHB-Lite slave port.
`include "self_program_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module self_program_flash_control
	import self_program_pkg::*;
#(
	parameter int unsigned OP_CYCLES = `OP_MIN_CYCLES
) (
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output var   logic [31:0] hrdata,
	output var   logic        hreadyout,
	output var   logic        hresp,
	input  wire  logic        store_program_instr,
	input  wire  logic        load_program_instr,
	input  wire  logic [15:0] z_pointer,
	input  wire  logic [15:0] data_register_pair,
	input  wire  logic        eeprom_write_busy,
	input  wire  logic        chip_erase,
	input  wire  logic [7:0]  fuse_low_pins,
	input  wire  logic [7:0]  fuse_high_pins,
	input  wire  logic [4:0]  buf_rd_index,
	output var   logic [15:0] buf_rd_data,
	output var   logic        cpu_halt,
	output var   logic [7:0]  load_data,
	output var   logic        load_valid,
	output var   logic        flash_erase_start,
	output var   logic        flash_write_start,
	output var   logic [9:0]  flash_page,
	output var   logic [1:0]  lock_bits,
	output var   logic        ext_prog_block,
	output var   logic        ext_verify_block,
	output var   logic        fuse_locked,
	output var   logic        debug_link_off,
	output var   logic        debug_read_allow
);

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic cmd_valid(input logic [4:0] c);
		cmd_valid = (c == `CMD_CLEAR_BUF) || (c == `CMD_READ_FUSE) || (c == `CMD_PAGE_WRITE)
			|| (c == `CMD_PAGE_ERASE) || (c == `CMD_FILL_BUF);
	endfunction

	localparam logic [31:0] CTRL_ADDR = {22'h00_0000, `CTRL_INDEX, 2'b00};

	seq_state_t  state_reg;
	op_kind_t    op_reg;
	logic [4:0]  ctrl_reg;
	logic [2:0]  win_reg;
	logic [16:0] timer_reg;
	logic        dp_wr_reg;
	logic        dp_hit_reg;
	logic [1:0]  lock_reg;
	logic [7:0]  fl_s1_reg;
	logic [7:0]  fl_s2_reg;
	logic [7:0]  fh_s1_reg;
	logic [7:0]  fh_s2_reg;
	logic [15:0] buf_mem [32];

	// ****************************************
	// AHB-Lite slave, zero wait states
	// ****************************************
	wire addr_phase = hsel & htrans[1] & hready;
	wire addr_hit   = (haddr == CTRL_ADDR);
	wire [31:0] rd_value = addr_hit ? {27'h000_0000, ctrl_reg} : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_reg  <= 1'b0;
			dp_hit_reg <= 1'b0;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			dp_wr_reg  <= addr_phase & hwrite;
			dp_hit_reg <= addr_phase & addr_hit;
			hrdata     <= (addr_phase & ~hwrite) ? rd_value : 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
	end

	// ****************************************
	// Fuse pins are static straps, synchronised anyway
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fl_s1_reg <= 8'h00;
			fl_s2_reg <= 8'h00;
			fh_s1_reg <= 8'h00;
			fh_s2_reg <= 8'h00;
		end else begin
			fl_s1_reg <= fuse_low_pins;
			fl_s2_reg <= fl_s1_reg;
			fh_s1_reg <= fuse_high_pins;
			fh_s2_reg <= fh_s1_reg;
		end
	end

	// ****************************************
	// Command sequencer
	// ****************************************
	wire [4:0] wr_cmd   = hwdata[4:0];
	// A command write is refused while busy or during an EEPROM write
	wire ctrl_write = dp_wr_reg & dp_hit_reg & (state_reg != ST_BUSY) & ~eeprom_write_busy;
	wire cmd_take   = ctrl_write & cmd_valid(wr_cmd);
	wire armed      = (state_reg == ST_ARMED) & ~cmd_take;
	wire store_take = armed & store_program_instr & ~eeprom_write_busy;
	wire load_take  = armed & ctrl_reg[`BIT_READ_FUSE] & load_program_instr
		& (win_reg >= `LOAD_WINDOW_MIN) & ~eeprom_write_busy;
	wire lapse      = armed & (win_reg == 3'h1) & ~store_take & ~load_take;
	wire is_erase   = (ctrl_reg == `CMD_PAGE_ERASE);
	wire is_write   = (ctrl_reg == `CMD_PAGE_WRITE);
	wire is_lock    = (ctrl_reg == `CMD_READ_FUSE);
	wire timed_op   = store_take & (is_erase | is_write | is_lock);
	wire op_done    = (state_reg == ST_BUSY) & (timer_reg == 17'h0_0000);
	wire buf_clear  = (cmd_take & (wr_cmd == `CMD_CLEAR_BUF))
		| (op_done & (op_reg == OP_WRITE));
	wire buf_fill   = store_take & (ctrl_reg == `CMD_FILL_BUF);
	wire [4:0] word_idx = z_pointer[5:1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			ctrl_reg  <= `CTRL_RESET;
			win_reg   <= 3'h0;
		end else if (cmd_take) begin
			state_reg <= ST_ARMED;
			ctrl_reg  <= wr_cmd;
			win_reg   <= `STORE_WINDOW;
		end else if (timed_op) begin
			state_reg <= ST_BUSY;
		end else if (store_take | load_take | lapse | op_done) begin
			state_reg <= ST_IDLE;
			ctrl_reg  <= `CTRL_RESET;
			win_reg   <= 3'h0;
		end else if (state_reg == ST_ARMED) begin
			win_reg <= win_reg - 3'h1;
		end
	end

	// ****************************************
	// Operation timer from the calibrated clock
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_reg         <= 17'h0_0000;
			op_reg            <= OP_ERASE;
			cpu_halt          <= 1'b0;
			flash_erase_start <= 1'b0;
			flash_write_start <= 1'b0;
			flash_page        <= 10'h000;
		end else begin
			flash_erase_start <= store_take & is_erase;
			flash_write_start <= store_take & is_write;
			if (timed_op) begin
				timer_reg  <= 17'(OP_CYCLES - 1);
				op_reg     <= is_erase ? OP_ERASE : (is_write ? OP_WRITE : OP_LOCK);
				cpu_halt   <= 1'b1;
				flash_page <= z_pointer[15:6];
			end else if (op_done) begin
				cpu_halt <= 1'b0;
			end else if (state_reg == ST_BUSY) begin
				timer_reg <= timer_reg - 17'h0_0001;
			end
		end
	end

	// ****************************************
	// Temporary page buffer
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 32; i++) begin
				buf_mem[i] <= `BUF_ERASED;
			end
			buf_rd_data <= `BUF_ERASED;
		end else begin
			if (buf_clear) begin
				for (int i = 0; i < 32; i++) begin
					buf_mem[i] <= `BUF_ERASED;
				end
			end else if (buf_fill) begin
				buf_mem[word_idx] <= data_register_pair;
			end
			buf_rd_data <= buf_mem[buf_rd_index];
		end
	end

	// ****************************************
	// Lock bits, fuse read and protection
	// ****************************************
	// Fuses and lock bits are active low: zero means programmed
	wire [7:0] fuse_sel = (z_pointer == `PTR_LOCK)      ? {6'h3f, lock_reg} :
	                      (z_pointer == `PTR_FUSE_HIGH) ? fh_s2_reg : fl_s2_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_reg         <= `LOCK_ERASED;
			load_data        <= 8'h00;
			load_valid       <= 1'b0;
			lock_bits        <= `LOCK_ERASED;
			ext_prog_block   <= 1'b0;
			ext_verify_block <= 1'b0;
			fuse_locked      <= 1'b0;
			debug_link_off   <= 1'b0;
			debug_read_allow <= 1'b0;
		end else begin
			if (chip_erase) begin
				lock_reg <= `LOCK_ERASED;
			end else if (store_take & is_lock) begin
				lock_reg <= lock_reg & data_register_pair[1:0];
			end
			load_valid       <= load_take;
			load_data        <= load_take ? fuse_sel : load_data;
			lock_bits        <= lock_reg;
			ext_prog_block   <= ~lock_reg[0];
			ext_verify_block <= ~lock_reg[0] & ~lock_reg[1];
			fuse_locked      <= ~lock_reg[0];
			debug_link_off   <= ~lock_reg[0];
			debug_read_allow <= ~fh_s2_reg[`DEBUG_LINK_ENABLE_FUSE_BIT];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	logic [16:0] halt_len_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_len_reg <= 17'h0_0000;
		end else begin
			halt_len_reg <= cpu_halt ? halt_len_reg + 17'h0_0001 : 17'h0_0000;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_arm_erase;
		cmd_take && (wr_cmd == `CMD_PAGE_ERASE) && !eeprom_write_busy;
	endsequence
	sequence s_store_now;
		store_program_instr && !eeprom_write_busy;
	endsequence

	a_reserved_zero: assert property (hrdata[31:5] == 27'h000_0000)
		else $error("reserved control bits read nonzero");
	a_window_lapse: assert property (lapse |=> ctrl_reg == 5'h00)
		else $error("command survived an empty window");
	a_erase_start: assert property (s_arm_erase ##1 s_store_now |=> flash_erase_start && cpu_halt)
		else $error("erase not started by store in window");
	a_halt_length: assert property ($fell(cpu_halt) |-> halt_len_reg == 17'(OP_CYCLES))
		else $error("operation length wrong");
	a_busy_holds_en: assert property ((state_reg == ST_BUSY) |-> ctrl_reg[0] && cpu_halt)
		else $error("store enable dropped during operation");
	a_lock_read: assert property (load_take && (z_pointer == `PTR_LOCK)
		|=> load_valid && (load_data == {6'h3f, $past(lock_reg)}))
		else $error("lock bits not returned");
	a_bad_cmd: assert property (ctrl_write && !cmd_valid(wr_cmd) && (state_reg == ST_IDLE)
		|=> state_reg == ST_IDLE)
		else $error("invalid command took effect");
	a_eeprom_block: assert property (eeprom_write_busy && (state_reg == ST_IDLE)
		|=> state_reg == ST_IDLE)
		else $error("command taken during eeprom write");
	a_mode3_block: assert property ((lock_reg == 2'h0) |=> ext_verify_block && ext_prog_block)
		else $error("mode 3 protection missing");
	a_buf_emptied: assert property (op_done && (op_reg == OP_WRITE)
		|=> buf_mem[0] == `BUF_ERASED)
		else $error("buffer not erased after page write");

	// ****************************************
	// Command paths, protection, fuse and timer checks
	// ****************************************
	sequence s_arm_write;
		cmd_take && (wr_cmd == `CMD_PAGE_WRITE) && !eeprom_write_busy;
	endsequence
	sequence s_arm_fill;
		cmd_take && (wr_cmd == `CMD_FILL_BUF) && !eeprom_write_busy;
	endsequence
	sequence s_arm_lock;
		cmd_take && (wr_cmd == `CMD_READ_FUSE) && !eeprom_write_busy;
	endsequence

	a_write_start: assert property (s_arm_write ##1 s_store_now |=> flash_write_start && cpu_halt)
		else $error("page write not started by store in window");
	a_fill_no_halt: assert property (s_arm_fill ##1 s_store_now |=> !cpu_halt && !flash_write_start)
		else $error("buffer fill halted the core");
	a_lock_halts: assert property (s_arm_lock ##1 s_store_now |=> cpu_halt && !flash_erase_start)
		else $error("lock write not timed");
	a_fill_clears: assert property (buf_fill |=> ctrl_reg == 5'h00)
		else $error("store enable kept after fill");
	a_clear_buffer: assert property (cmd_take && (wr_cmd == `CMD_CLEAR_BUF) |=> buf_mem[31] == `BUF_ERASED)
		else $error("buffer not cleared by clear command");
	a_start_pulse: assert property (flash_erase_start |=> !flash_erase_start)
		else $error("erase start longer than one cycle");
	a_halt_busy: assert property (cpu_halt |-> state_reg == ST_BUSY)
		else $error("core halted outside an operation");
	a_halt_no_start: assert property (cpu_halt && $past(cpu_halt) |-> !flash_erase_start && !flash_write_start)
		else $error("second start during an operation");
	a_load_one: assert property (load_valid |=> !load_valid)
		else $error("load answer longer than one cycle");
	a_fuse_high: assert property (load_take && (z_pointer == `PTR_FUSE_HIGH)
		|=> load_data == $past(fh_s2_reg))
		else $error("fuse high byte not returned");
	a_mode1_free: assert property ((lock_reg == `LOCK_ERASED)
		|=> !ext_prog_block && !ext_verify_block && !debug_link_off)
		else $error("restriction with both lock bits one");
	a_mode2_verify: assert property (lock_reg[1] |=> !ext_verify_block)
		else $error("verification blocked in mode 2");
	a_chip_erase: assert property (chip_erase |=> lock_reg == `LOCK_ERASED)
		else $error("chip erase left lock bits programmed");
	a_lock_only_down: assert property (!chip_erase
		|=> (lock_reg & ~$past(lock_reg)) == 2'h0)
		else $error("lock bit returned to one without chip erase");
	a_dbg_read: assert property (!fh_s2_reg[`DEBUG_LINK_ENABLE_FUSE_BIT] |=> debug_read_allow)
		else $error("debug read not allowed");
	a_lapse_idle: assert property ((state_reg == ST_ARMED) && (win_reg == 3'h1)
		&& !store_program_instr && !cmd_take |=> state_reg == ST_IDLE)
		else $error("store window longer than four cycles");
	a_read_window: assert property (load_program_instr && (win_reg == 3'h1)
		&& !cmd_take |=> !load_valid)
		else $error("load taken after three cycles");
	a_eeprom_store: assert property (eeprom_write_busy |=> !flash_erase_start && !flash_write_start)
		else $error("store taken during eeprom write");
	a_page_latched: assert property (timed_op && (is_erase || is_write)
		|=> flash_page == $past(z_pointer[15:6]))
		else $error("wrong page latched");
	a_done_clears: assert property (op_done |=> (ctrl_reg == 5'h00) && !cpu_halt)
		else $error("command kept after operation");
	a_busy_keeps: assert property ((state_reg == ST_BUSY) && !op_done
		|=> ctrl_reg == $past(ctrl_reg))
		else $error("control changed during operation");
	a_fill_word: assert property (buf_fill
		|=> buf_mem[$past(word_idx)] == $past(data_register_pair))
		else $error("buffer word not written");
	a_timer_bound: assert property (timer_reg <= 17'(OP_CYCLES - 1))
		else $error("operation timer out of range");

endmodule

`default_nettype wire

// ==== tb/cpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// CPU core issuing store and load program instructions
// ****************************************
module cpu_core_model (
	input  wire logic        hclk,
	input  wire logic        cpu_halt,
	input  wire logic        load_valid,
	input  wire logic [7:0]  load_data,
	output var  logic        store_program_instr,
	output var  logic        load_program_instr,
	output var  logic [15:0] z_pointer,
	output var  logic [15:0] data_register_pair
);
	initial begin
		store_program_instr = 1'b0;
		load_program_instr = 1'b0;
		z_pointer = 16'h0000;
		data_register_pair = 16'h0000;
	end

	// A halted core fetches nothing, so no store strobe while halted
	// Released lines show the inverse, so stale sampling is seen
	task automatic store(input logic [15:0] z, input logic [15:0] d);
		while (cpu_halt !== 1'b0) @(posedge hclk);
		z_pointer <= z;
		data_register_pair <= d;
		store_program_instr <= 1'b1;
		@(posedge hclk);
		store_program_instr <= 1'b0;
		z_pointer <= ~z;
		data_register_pair <= ~d;
	endtask

	task automatic load(input logic [15:0] z, output logic [7:0] v);
		z_pointer <= z;
		load_program_instr <= 1'b1;
		@(posedge hclk);
		load_program_instr <= 1'b0;
		z_pointer <= ~z;
		@(negedge hclk);
		v = (load_valid === 1'b1) ? load_data : 8'hxx;
	endtask
endmodule

`default_nettype wire

// ==== tb/self_program_flash_control_bench.sv ====
`include "self_program_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module self_program_flash_control_bench;
	localparam int          OPN  = 20;
	localparam logic [31:0] CTRL = {22'h0, `CTRL_INDEX, 2'b00};
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans, lock_bits;
	logic [2:0]  hsize;
	logic        spi, lpi, eeprom_write_busy, chip_erase, cpu_halt, load_valid;
	logic        fes, fws, epb, evb, fl, dlo, dra;
	logic [15:0] z, d, buf_rd_data;
	logic [7:0]  fuse_low_pins, fuse_high_pins, load_data, v;
	logic [9:0]  flash_page;
	logic [4:0]  buf_rd_index;
	int          n_mismatch, checks_done, halt_cycles, i;
	logic [4:0]  cmds [6] = '{5'h01, 5'h03, 5'h05, 5'h09, 5'h07, 5'h1f};
	logic [15:0] zs [3] = '{16'h0001, 16'h0000, 16'h0003};
	logic [7:0]  fz [3] = '{8'hff, 8'h62, 8'hdf};

	assign hready = hreadyout;

	self_program_flash_control #(.OP_CYCLES(OPN)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .store_program_instr(spi), .load_program_instr(lpi),
		.z_pointer(z), .data_register_pair(d), .eeprom_write_busy(eeprom_write_busy),
		.chip_erase(chip_erase), .fuse_low_pins(fuse_low_pins),
		.fuse_high_pins(fuse_high_pins), .buf_rd_index(buf_rd_index),
		.buf_rd_data(buf_rd_data), .cpu_halt(cpu_halt), .load_data(load_data),
		.load_valid(load_valid), .flash_erase_start(fes), .flash_write_start(fws),
		.flash_page(flash_page), .lock_bits(lock_bits), .ext_prog_block(epb),
		.ext_verify_block(evb), .fuse_locked(fl), .debug_link_off(dlo),
		.debug_read_allow(dra));

	cpu_core_model cpu (.hclk(hclk), .cpu_halt(cpu_halt), .load_valid(load_valid),
		.load_data(load_data), .store_program_instr(spi), .load_program_instr(lpi),
		.z_pointer(z), .data_register_pair(d));

	always #25 hclk = ~hclk;
	always @(posedge hclk) if (cpu_halt === 1'b1) halt_cycles <= halt_cycles + 1;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	// Lock writes halt too, so one task serves all timed operations
	task automatic op(input logic [4:0] c, input logic [15:0] zv, dv, input logic [1:0] st);
		ahb(1'b1, CTRL, {27'h0, c});
		halt_cycles = 0;
		cpu.store(zv, dv);
		@(negedge hclk);
		chk({fes, fws, cpu_halt}, {st, 1'b1});
		if (st != 2'b00) chk(flash_page, zv[15:6]);
		@(posedge hclk);
		ahb(1'b0, CTRL, 0);
		chk(r, {27'h0, c});
		for (i = 0; i < 100 && cpu_halt !== 1'b0; i++) @(negedge hclk);
		chk(halt_cycles, OPN);
		@(posedge hclk);
		ahb(1'b0, CTRL, 0);
		chk(r, 0);
	endtask

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{hclk, hresetn, hsel, hwrite, eeprom_write_busy, chip_erase} = 6'h00;
		{haddr, hwdata, htrans, hsize, buf_rd_index} = {64'h0, 2'b00, 3'b010, 5'h00};
		fuse_low_pins = 8'h62; // Fuses settled before any lock write
		fuse_high_pins = 8'hdf;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		ahb(1'b0, CTRL, 0);
		chk(r, 0);
		chk({hreadyout, hresp}, 2'b10);
		ahb(1'b0, 32'h0000_0100, 0);
		chk(r, 0);
		ahb(1'b1, CTRL, 32'hffff_ffe1);
		ahb(1'b0, CTRL, 0);
		chk(r, 32'h0000_0001);
		for (i = 0; i < 6; i++) begin
			ahb(1'b1, CTRL, {27'h0, cmds[i]});
			repeat (5) @(posedge hclk);
			ahb(1'b0, CTRL, 0);
			chk(r, 0);
		end
		ahb(1'b1, CTRL, `CMD_FILL_BUF);
		cpu.store(16'h0043, 16'h1234);
		buf_rd_index <= 5'h01;
		ahb(1'b0, CTRL, 0);
		chk(r, 0);
		chk(buf_rd_data, 16'h1234);
		ahb(1'b1, CTRL, `CMD_CLEAR_BUF);
		repeat (5) @(posedge hclk);
		chk(buf_rd_data, 16'hffff);
		ahb(1'b1, CTRL, `CMD_FILL_BUF);
		cpu.store(16'h0042, 16'habcd);
		op(`CMD_PAGE_ERASE, 16'h0040, 16'h5555, 2'b10);
		chk(buf_rd_data, 16'habcd);
		op(`CMD_PAGE_WRITE, 16'h0080, 16'h5555, 2'b01);
		@(posedge hclk);
		chk(buf_rd_data, 16'hffff);
		for (i = 0; i < 3; i++) begin
			ahb(1'b1, CTRL, `CMD_READ_FUSE);
			cpu.load(zs[i], v);
			chk(v, fz[i]);
			@(posedge hclk);
		end
		op(`CMD_READ_FUSE, 16'h0000, 16'hfffe, 2'b00);
		chk({lock_bits, epb, evb, fl, dlo}, 6'h2b);
		ahb(1'b1, CTRL, `CMD_READ_FUSE);
		cpu.load(16'h0001, v);
		chk(v, 8'hfe);
		@(posedge hclk);
		op(`CMD_READ_FUSE, 16'h0000, 16'hfffc, 2'b00);
		chk({lock_bits, epb, evb, fl, dlo}, 6'h0f);
		chip_erase <= 1'b1;
		@(posedge hclk);
		chip_erase <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({lock_bits, epb, evb, fl, dlo}, 6'h30);
		fuse_high_pins <= 8'h9f;
		repeat (4) @(posedge hclk);
		chk(dra, 1'b1);
		eeprom_write_busy <= 1'b1;
		ahb(1'b1, CTRL, `CMD_FILL_BUF);
		ahb(1'b0, CTRL, 0);
		chk(r, 0);
		test_done;
	end

	initial begin
		repeat (5000) @(posedge hclk);
		n_mismatch++;
		test_done;
	end
endmodule

`default_nettype wire
